// ===== hw/zone_box.sv
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
// Function
// - Commutation error disables that channel's motor.
// - Recovery re-enables channel without manual acknowledge.
// - Recovery works in central and zone modes.
// - Per-channel attempt limit; zero disables recovery.
// - Beyond limit, hold error until manual acknowledge.
// - Wait configured milliseconds before automatic acknowledge.
// - Count automatic recoveries; manual acknowledge clears.
// - Report milliseconds since last automatic acknowledge.
// - Each zone drives one motor, reads one sensor.
// - Forward only into free or emptying zone.
// - Arriving package stops motor until downstream free.
// - Zone emptied signals free to upstream.
// - Upstream announces package, both motors then run.
// - Singulated release: free after package leaves sensor.
// - Train release: free once package starts leaving.
// - Channels inside box link through internal signals.
// - Neighbour handshake selectable: pins or fieldbus data.
module zone_box #(
  parameter int MS_CYCLES = zone_pkg::MS_CYCLES
) (
  input  logic        core_clk,
  input  logic        reset,
  input  logic        cyc_i,
  input  logic        stb_i,
  input  logic        we_i,
  input  logic [7:0]  adr_i,
  input  logic [3:0]  sel_i,
  input  logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic        ack_o,
  input  logic [1:0]  sensorPin,
  input  logic [1:0]  commErrPin,
  output logic [1:0]  motorEn,
  output logic        irq,
  zone_link_if.dev    link
);
  localparam int PW = zone_pkg::PINS;
  localparam int MW = zone_pkg::MSW;
  localparam int IW = zone_pkg::IRQ_W;

  typedef struct packed {
    logic [PW-1:0]      s1;
    logic [PW-1:0]      s2;
    logic [PW-1:0]      s3;
    logic [PW-1:0]      filt;
    logic [1:0]         errPrev;
    logic [7:0]         ctrl;
    logic [15:0]        limit;
    logic [31:0]        delay;
    logic [1:0]         pdoIn;
    logic [1:0]         fault;
    logic [1:0]         locked;
    logic [1:0][7:0]    cnt;
    logic [1:0][15:0]   dly;
    logic [1:0][15:0]   elapsed;
    logic [MW-1:0]      msCnt;
    logic               msTick;
    logic [IW-1:0]      irqStat;
    logic [IW-1:0]      irqEn;
    logic               ack;
    logic [31:0]        datOut;
    logic [1:0]         motor;
    logic               irq;
    logic               upFree;
    logic               dnComing;
  } box_s;

  box_s          r;
  box_s          n;
  logic          access;
  logic          wr;
  logic [31:0]   wmask;
  logic [1:0]    manAck;
  logic [IW-1:0] evSet;
  logic [IW-1:0] evClr;
  logic [PW-1:0] agree;
  logic [1:0]    zUpFree;
  logic [1:0]    zDnComing;
  logic [1:0]    zMotor;
  logic [1:0]    zUpComing;
  logic [1:0]    zDnFree;
  logic          fieldbus;

  assign wmask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign fieldbus = r.ctrl[zone_pkg::CTRL_FIELDBUS];

  // ============================================================
  // Zone channels. Channel 0 faces upstream, channel 1 downstream.
  // In fieldbus mode the neighbour handshake comes from software instead of the pins.
  assign zUpComing = {zDnComing[0], fieldbus ? r.pdoIn[0] : r.filt[zone_pkg::PIN_UPCOM]};
  assign zDnFree   = {fieldbus ? r.pdoIn[1] : r.filt[zone_pkg::PIN_DNFREE], zUpFree[1]};

  generate
    for (genvar c = 0; c < 2; c++) begin : g_zone
      zone_channel u_zone (
        .core_clk (core_clk),
        .reset    (reset),
        .enable   (r.ctrl[zone_pkg::CTRL_ZONE_EN + c]),
        .train    (r.ctrl[zone_pkg::CTRL_TRAIN + c]),
        .sensor   (r.filt[zone_pkg::PIN_SENSOR + c]),
        .upComing (zUpComing[c]),
        .dnFree   (zDnFree[c]),
        .upFree   (zUpFree[c]),
        .dnComing (zDnComing[c]),
        .motor    (zMotor[c])
      );
    end
  endgenerate

  // ============================================================
  // Next state.
  always_comb begin
    n      = r;
    access = cyc_i & stb_i & ~r.ack;
    wr     = access & we_i;
    manAck = 2'h0;
    evSet  = '0;
    evClr  = '0;
    n.ack  = access;

    // Pins come from outside the box, so a change only counts once the last two stages agree.
    n.s1  = {link.dnFree, link.upComing, commErrPin, sensorPin};
    n.s2  = r.s1;
    n.s3  = r.s2;
    agree = ~(r.s2 ^ r.s3);
    n.filt = (r.filt & ~agree) | (r.s3 & agree);

    n.msTick = (r.msCnt == MW'(MS_CYCLES - 1));
    n.msCnt  = n.msTick ? '0 : r.msCnt + MW'(1);

    // ============================================================
    // Register writes.
    if (wr) begin
      case (adr_i)
        zone_pkg::ADR_CTRL:    n.ctrl  = (r.ctrl & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
        zone_pkg::ADR_LIMIT:   n.limit = (r.limit & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
        zone_pkg::ADR_DELAY:   n.delay = (r.delay & ~wmask) | (dat_i & wmask);
        zone_pkg::ADR_ACK:     manAck  = dat_i[1:0] & wmask[1:0];
        zone_pkg::ADR_PDO_IN:  n.pdoIn = (r.pdoIn & ~wmask[1:0]) | (dat_i[1:0] & wmask[1:0]);
        zone_pkg::ADR_IRQ_CLR: evClr   = dat_i[IW-1:0] & wmask[IW-1:0];
        zone_pkg::ADR_IRQ_EN:  n.irqEn = (r.irqEn & ~wmask[IW-1:0]) | (dat_i[IW-1:0] & wmask[IW-1:0]);
        default: begin
        end
      endcase
    end

    // ============================================================
    // Error recovery per channel.
    n.errPrev = r.filt[zone_pkg::PIN_ERR +: 2];
    for (int c = 0; c < 2; c++) begin
      if (r.msTick && r.elapsed[c] != 16'hFFFF) begin
        n.elapsed[c] = r.elapsed[c] + 16'h1;
      end
      if (manAck[c]) begin
        n.fault[c]  = 1'b0;
        n.locked[c] = 1'b0;
        n.cnt[c]    = 8'h0;
      end
      // An error edge in the acknowledge cycle still faults the channel again.
      if (r.filt[zone_pkg::PIN_ERR + c] && !r.errPrev[c] && !n.fault[c]) begin
        n.fault[c] = 1'b1;
        evSet[zone_pkg::IRQ_FAULT + c] = 1'b1;
        if (r.limit[8*c +: 8] == 8'h0 || n.cnt[c] >= r.limit[8*c +: 8]) begin
          n.locked[c] = 1'b1;
          evSet[zone_pkg::IRQ_LOCK + c] = 1'b1;
        end else begin
          n.dly[c] = 16'h0;
        end
      end else if (r.fault[c] && !r.locked[c] && !manAck[c] && r.msTick) begin
        if (r.dly[c] >= r.delay[16*c +: 16]) begin
          n.fault[c]   = 1'b0;
          n.cnt[c]     = r.cnt[c] + 8'h1;
          n.elapsed[c] = 16'h0;
          evSet[zone_pkg::IRQ_AUTO + c] = 1'b1;
        end else begin
          n.dly[c] = r.dly[c] + 16'h1;
        end
      end
      // A faulted channel is cut off whichever source commands it.
      n.motor[c] = (r.ctrl[zone_pkg::CTRL_CENTRAL] ? r.ctrl[zone_pkg::CTRL_RUN + c] : zMotor[c])
                   & ~n.fault[c];
    end

    // A new event wins over a clear in the same cycle.
    n.irqStat  = (r.irqStat & ~evClr) | evSet;
    n.irq      = |(n.irqStat & n.irqEn);
    n.upFree   = ~fieldbus & zUpFree[0];
    n.dnComing = ~fieldbus & zDnComing[1];

    // ============================================================
    // Register reads.
    n.datOut = 32'h0000_0000;
    if (access && !we_i) begin
      case (adr_i)
        zone_pkg::ADR_CTRL:    n.datOut = {24'h00_0000, r.ctrl};
        zone_pkg::ADR_LIMIT:   n.datOut = {16'h0000, r.limit};
        zone_pkg::ADR_DELAY:   n.datOut = r.delay;
        zone_pkg::ADR_STATUS:  n.datOut = {8'h00, r.filt[1:0], r.motor, r.locked, r.fault, r.cnt[1], r.cnt[0]};
        zone_pkg::ADR_ELAPSED: n.datOut = {r.elapsed[1], r.elapsed[0]};
        zone_pkg::ADR_PDO_IN:  n.datOut = {30'h0000_0000, r.pdoIn};
        zone_pkg::ADR_PDO_OUT: n.datOut = {30'h0000_0000, zDnComing[1], zUpFree[0]};
        zone_pkg::ADR_IRQ_ST:  n.datOut = {26'h000_0000, r.irqStat};
        zone_pkg::ADR_IRQ_EN:  n.datOut = {26'h000_0000, r.irqEn};
        default:               n.datOut = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r       <= '0;
      r.ctrl  <= zone_pkg::CTRL_RST;
      r.limit <= zone_pkg::LIMIT_RST;
      r.delay <= zone_pkg::DELAY_RST;
    end else begin
      r <= n;
    end
  end

  assign dat_o         = r.datOut;
  assign ack_o         = r.ack;
  assign motorEn       = r.motor;
  assign irq           = r.irq;
  assign link.upFree   = r.upFree;
  assign link.dnComing = r.dnComing;
endmodule

// ===== hw/zone_channel.sv
`timescale 1ns/1ns
// ============================================================
// One accumulation zone: one roller motor and one presence sensor.
module zone_channel (
  input  logic core_clk,
  input  logic reset,
  input  logic enable,
  input  logic train,
  input  logic sensor,
  input  logic upComing,
  input  logic dnFree,
  output logic upFree,
  output logic dnComing,
  output logic motor
);
  typedef struct packed {
    zone_pkg::zone_state_e st;
    logic                  pend;
    logic                  free;
    logic                  coming;
    logic                  motor;
  } zone_s;

  zone_s r;
  zone_s n;

  // ============================================================
  // Zone sequence.
  always_comb begin
    n = r;
    case (r.st)
      zone_pkg::ZONE_IDLE: begin
        if (enable && sensor) begin
          n.st = zone_pkg::ZONE_HOLD;
        end else if (enable && upComing) begin
          n.st = zone_pkg::ZONE_RECV;
        end
      end
      zone_pkg::ZONE_RECV: begin
        if (sensor) begin
          n.st = zone_pkg::ZONE_HOLD;
        end
      end
      zone_pkg::ZONE_HOLD: begin
        if (!sensor) begin
          n.st = zone_pkg::ZONE_IDLE;
        end else if (dnFree) begin
          n.st   = zone_pkg::ZONE_SEND;
          n.pend = 1'b0;
        end
      end
      zone_pkg::ZONE_SEND: begin
        if (upComing && train) begin
          n.pend = 1'b1;
        end
        if (!sensor) begin
          n.st = n.pend ? zone_pkg::ZONE_RECV : zone_pkg::ZONE_IDLE;
        end
      end
      default: begin
        n.st = zone_pkg::ZONE_IDLE;
      end
    endcase
    // Free stays up until the upstream side announces a package or the zone fills again.
    n.free   = enable && (n.st == zone_pkg::ZONE_IDLE ||
               (n.st == zone_pkg::ZONE_SEND && train && !n.pend));
    n.coming = (n.st == zone_pkg::ZONE_SEND);
    n.motor  = enable && (n.st == zone_pkg::ZONE_RECV || n.st == zone_pkg::ZONE_SEND);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign upFree   = r.free;
  assign dnComing = r.coming;
  assign motor    = r.motor;
endmodule

// ===== hw/zone_link_if.sv
`timescale 1ns/1ns
// ============================================================
// Handshake wires between this box and the neighbouring boxes.
interface zone_link_if;
  logic upFree;
  logic upComing;
  logic dnComing;
  logic dnFree;
  modport dev (output upFree, input upComing, output dnComing, input dnFree);
  modport nbr (input upFree, output upComing, input dnComing, output dnFree);
endinterface

// ===== hw/zone_neighbors.sv
`timescale 1ns/1ns
// ============================================================
// The zones of the adjacent boxes: one upstream of the box, one downstream.
module zone_neighbors (
  input  logic     core_clk,
  input  logic     reset,
  zone_link_if.nbr link,
  input  logic     feedComing,
  input  logic     upSensor,
  input  logic     upTrain,
  input  logic     dnSensor,
  input  logic     dnTrain,
  input  logic     exitFree,
  output logic     upMotor,
  output logic     dnMotor
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] filt;
  } nbr_s;

  nbr_s       r;
  nbr_s       n;
  logic [1:0] agree;

  // ============================================================
  // Link wires arrive from another box and are filtered like any pin.
  always_comb begin
    n      = r;
    n.s1   = {link.dnComing, link.upFree};
    n.s2   = r.s1;
    n.s3   = r.s2;
    agree  = ~(r.s2 ^ r.s3);
    n.filt = (r.filt & ~agree) | (r.s3 & agree);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Upstream zone sends into the box only once the box reports free.
  zone_channel u_up (
    .core_clk (core_clk),
    .reset    (reset),
    .enable   (1'b1),
    .train    (upTrain),
    .sensor   (upSensor),
    .upComing (feedComing),
    .dnFree   (r.filt[0]),
    .upFree   (),
    .dnComing (link.upComing),
    .motor    (upMotor)
  );

  zone_channel u_dn (
    .core_clk (core_clk),
    .reset    (reset),
    .enable   (1'b1),
    .train    (dnTrain),
    .sensor   (dnSensor),
    .upComing (r.filt[1]),
    .dnFree   (exitFree),
    .upFree   (link.dnFree),
    .dnComing (),
    .motor    (dnMotor)
  );
endmodule

// ===== hw/zone_pkg.sv
// ============================================================
// Shared constants for the zone box and its neighbours.
package zone_pkg;
  // ============================================================
  // Timing.
  localparam int CLK_NS    = 10;
  localparam int MS_NS     = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int MSW       = 17;

  // ============================================================
  // Register byte addresses.
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_LIMIT   = 8'h04;
  localparam logic [7:0] ADR_DELAY   = 8'h08;
  localparam logic [7:0] ADR_ACK     = 8'h0C;
  localparam logic [7:0] ADR_STATUS  = 8'h10;
  localparam logic [7:0] ADR_ELAPSED = 8'h14;
  localparam logic [7:0] ADR_PDO_IN  = 8'h18;
  localparam logic [7:0] ADR_PDO_OUT = 8'h1C;
  localparam logic [7:0] ADR_IRQ_ST  = 8'h20;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h24;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h28;

  // ============================================================
  // Control fields and reset values.
  localparam int CTRL_FIELDBUS = 0;
  localparam int CTRL_TRAIN    = 1;
  localparam int CTRL_ZONE_EN  = 3;
  localparam int CTRL_CENTRAL  = 5;
  localparam int CTRL_RUN      = 6;
  localparam logic [7:0]  CTRL_RST  = 8'h18;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [31:0] DELAY_RST = 32'h0064_0064;

  // ============================================================
  // Interrupt bits and synchronised pin positions.
  localparam int IRQ_FAULT  = 0;
  localparam int IRQ_LOCK   = 2;
  localparam int IRQ_AUTO   = 4;
  localparam int IRQ_W      = 6;
  localparam int PIN_SENSOR = 0;
  localparam int PIN_ERR    = 2;
  localparam int PIN_UPCOM  = 4;
  localparam int PIN_DNFREE = 5;
  localparam int PINS       = 6;

  typedef enum logic [1:0] {
    ZONE_IDLE = 2'h0,
    ZONE_RECV = 2'h1,
    ZONE_HOLD = 2'h3,
    ZONE_SEND = 2'h2
  } zone_state_e;
endpackage

// ===== tb/test_zone_conveyor_error_recovery.sv
`timescale 1ns/1ns
// ============================================================
// Two packages through the box, then fault recovery and the fieldbus handshake.
module test_zone_conveyor_error_recovery;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] datO;
  logic        ack;
  logic [1:0]  sensorPin = 2'h0;
  logic [1:0]  commErrPin = 2'h0;
  logic [1:0]  motorEn;
  logic        irq;
  logic        upSensor = 1'b0;
  logic        dnSensor = 1'b1;
  logic        upMotor;
  logic        dnMotor;
  logic [8:0]  obs;
  logic [31:0] q;
  int          seed = 32'hbd1a_ea8d;
  int          d;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles = 0;

  zone_link_if lnk ();
  zone_box #(.MS_CYCLES(20)) i_zone_box (.core_clk(core_clk), .reset(reset), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ack), .sensorPin(sensorPin),
    .commErrPin(commErrPin), .motorEn(motorEn), .irq(irq), .link(lnk));
  // Feed and exit stay quiet so that each package is released by hand, one at a time.
  zone_neighbors i_zone_neighbors (.core_clk(core_clk), .reset(reset), .link(lnk), .feedComing(1'b0),
    .upSensor(upSensor), .upTrain(1'b0), .dnSensor(dnSensor), .dnTrain(1'b0), .exitFree(1'b0),
    .upMotor(upMotor), .dnMotor(dnMotor));
  zone_link_checker i_zone_link_checker (.core_clk(core_clk), .reset(reset), .upFree(lnk.upFree),
    .upComing(lnk.upComing), .dnComing(lnk.dnComing), .dnFree(lnk.dnFree));

  assign obs = {irq, dnMotor, upMotor, lnk.dnFree, lnk.dnComing, lnk.upComing, lnk.upFree, motorEn};

  always #5 core_clk = ~core_clk;

  // ============================================================
  // Helpers.
  function automatic logic [31:0] stat(logic [7:0] c0, logic [7:0] c1, logic [1:0] flt, logic [1:0] lk);
    stat = {12'h000, lk, flt, c1, c0};
  endfunction

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i;
    i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= v;
    do begin
      @(posedge core_clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = datO;
    chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask

  // Waits on one observed bit; a slow design shows up as a mismatch, not a hang.
  task automatic wt(input int b, input logic v);
    int i;
    i = 0;
    while (obs[b] !== v && i < 100) begin
      @(posedge core_clk);
      i++;
    end
    chk(obs[b], v);
  endtask

  task automatic err(input int c);
    commErrPin[c] <= 1'b1;
    repeat (4) @(posedge core_clk);
    commErrPin[c] <= 1'b0;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ============================================================
  // Main sequence.
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(zone_pkg::ADR_CTRL, 32'hFFFF_FFFF, 32'h0000_0018);
    rd(zone_pkg::ADR_LIMIT, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(zone_pkg::ADR_DELAY, 32'hFFFF_FFFF, 32'h0064_0064);
    rd(8'h2C, 32'hFFFF_FFFF, 32'h0000_0000);
    wt(2, 1'b1);
    upSensor <= 1'b1;
    wt(3, 1'b1);
    wt(0, 1'b1);
    chk(upMotor, 1'b1);
    sensorPin <= 2'h1;
    upSensor <= 1'b0;
    wt(1, 1'b1);
    sensorPin <= 2'h2;
    wt(1, 1'b0);
    chk(lnk.dnComing, 1'b0);
    upSensor <= 1'b1;
    wt(0, 1'b1);
    sensorPin <= 2'h3;
    upSensor <= 1'b0;
    wt(0, 1'b0);
    dnSensor <= 1'b0;
    wt(4, 1'b1);
    wt(1, 1'b1);
    wt(7, 1'b1);
    chk(motorEn[0], 1'b0);
    sensorPin <= 2'h1;
    wt(0, 1'b1);
    sensorPin <= 2'h0;
    d = {$random(seed)} % 3 + 1;
    wb(1'b1, zone_pkg::ADR_LIMIT, 32'h0000_0001);
    wb(1'b1, zone_pkg::ADR_DELAY, {16'h0001, d[15:0]});
    wb(1'b1, zone_pkg::ADR_CTRL, 32'h0000_00F8);
    wt(1, 1'b1);
    err(0);
    wt(0, 1'b0);
    repeat (d * 20 - 8) @(posedge core_clk);
    chk(motorEn[0], 1'b0);
    wt(0, 1'b1);
    rd(zone_pkg::ADR_STATUS, 32'h000F_FFFF, stat(8'h01, 8'h00, 2'h0, 2'h0));
    wb(1'b0, zone_pkg::ADR_ELAPSED, 32'h0000_0000);
    chk(q[15:0] <= 16'h0001, 1'b1);
    repeat (60) @(posedge core_clk);
    wb(1'b0, zone_pkg::ADR_ELAPSED, 32'h0000_0000);
    chk(q[15:0] inside {16'h0003, 16'h0004}, 1'b1);
    chk(irq, 1'b0);
    wb(1'b1, zone_pkg::ADR_IRQ_EN, 32'h0000_0010);
    wt(8, 1'b1);
    wb(1'b1, zone_pkg::ADR_IRQ_CLR, 32'h0000_0010);
    wt(8, 1'b0);
    rd(zone_pkg::ADR_IRQ_ST, 32'h0000_003F, 32'h0000_0001);
    err(0);
    wt(0, 1'b0);
    repeat ((d + 2) * 20) @(posedge core_clk);
    chk(motorEn[0], 1'b0);
    rd(zone_pkg::ADR_STATUS, 32'h000C_00FF, stat(8'h01, 8'h00, 2'h0, 2'h1));
    wb(1'b1, zone_pkg::ADR_ACK, 32'h0000_0001);
    wt(0, 1'b1);
    rd(zone_pkg::ADR_STATUS, 32'h000F_00FF, stat(8'h00, 8'h00, 2'h0, 2'h0));
    err(1);
    wt(1, 1'b0);
    repeat (60) @(posedge core_clk);
    chk(motorEn[1], 1'b0);
    rd(zone_pkg::ADR_STATUS, 32'h000C_FF00, stat(8'h00, 8'h00, 2'h0, 2'h2));
    wb(1'b1, zone_pkg::ADR_ACK, 32'h0000_0002);
    wt(1, 1'b1);
    wb(1'b1, zone_pkg::ADR_CTRL, 32'h0000_0019);
    wt(2, 1'b0);
    rd(zone_pkg::ADR_PDO_OUT, 32'h0000_0001, 32'h0000_0001);
    wb(1'b1, zone_pkg::ADR_PDO_IN, 32'h0000_0001);
    wt(0, 1'b1);
    rd(zone_pkg::ADR_PDO_OUT, 32'h0000_0001, 32'h0000_0000);
    // Train release on zone 0, with the downstream neighbour reached through process data.
    wb(1'b1, zone_pkg::ADR_CTRL, 32'h0000_001B);
    sensorPin <= 2'h3;
    wt(0, 1'b0);
    wb(1'b1, zone_pkg::ADR_PDO_IN, 32'h0000_0002);
    wt(1, 1'b1);
    rd(zone_pkg::ADR_PDO_OUT, 32'h0000_0003, 32'h0000_0002);
    sensorPin <= 2'h1;
    wt(0, 1'b1);
    rd(zone_pkg::ADR_PDO_OUT, 32'h0000_0001, 32'h0000_0001);
    wb(1'b1, zone_pkg::ADR_PDO_IN, 32'h0000_0003);
    rd(zone_pkg::ADR_PDO_OUT, 32'h0000_0001, 32'h0000_0000);
    // Recovery while the zone logic drives the motor, with no delay.
    wb(1'b1, zone_pkg::ADR_DELAY, 32'h0001_0000);
    err(0);
    wt(0, 1'b0);
    wt(0, 1'b1);
    test_done();
  end
endmodule

// ===== tb/zone_link_checker.sv
`timescale 1ns/1ns
// ============================================================
// Handshake checks on the wires between the box and its neighbours.
module zone_link_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic upFree,
  input wire logic upComing,
  input wire logic dnComing,
  input wire logic dnFree
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ============================================================
  // Steps of a transfer: the receiver drops free once it sees the package announced.
  sequence s_up_taken;
    upFree [*6] ##1 !upFree;
  endsequence
  sequence s_dn_taken;
    dnFree [*3] ##[1:3] !dnFree;
  endsequence

  // ============================================================
  // Three flops of input filtering mean an announcement can never follow free sooner.
  property p_up_after_free;
    $rose(upComing) |-> $past(upFree, 3);
  endproperty
  property p_dn_after_free;
    $rose(dnComing) |-> $past(dnFree, 3);
  endproperty
  property p_up_taken;
    $rose(upComing) |-> s_up_taken;
  endproperty
  property p_dn_taken;
    $rose(dnComing) |-> s_dn_taken;
  endproperty
  property p_up_coming_held;
    $rose(upComing) |-> upComing [*4];
  endproperty
  property p_dn_coming_held;
    $rose(dnComing) |-> dnComing [*4];
  endproperty
  property p_up_free_held;
    $rose(upFree) |-> upFree [*3];
  endproperty
  property p_dn_free_held;
    $rose(dnFree) |-> dnFree [*3];
  endproperty

  a_up_after_free:
    assert property (p_up_after_free) else $error("upstream announced into a busy zone");
  a_dn_after_free:
    assert property (p_dn_after_free) else $error("box announced into a busy zone");
  a_up_taken:
    assert property (p_up_taken) else $error("box free not withdrawn after announcement");
  a_dn_taken:
    assert property (p_dn_taken) else $error("downstream free not withdrawn after announcement");
  a_up_coming_held:
    assert property (p_up_coming_held) else $error("upstream announcement too short");
  a_dn_coming_held:
    assert property (p_dn_coming_held) else $error("box announcement too short");
  a_up_free_held:
    assert property (p_up_free_held) else $error("box free too short");
  a_dn_free_held:
    assert property (p_dn_free_held) else $error("downstream free too short");
endmodule
